// File: carrier_loop_pkg.sv
// Purpose: shared constants and types for the carrier frequency error and loop input block
// Assumes: AHB-Lite word registers, byte address is four times the register index
// Notes:   all control values start at zero after reset

package carrier_loop_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [29:0] IDX_DISC = 30'h4;   // discriminator delay
  localparam logic [29:0] IDX_FED  = 30'h5;   // frequency error detector control
  localparam logic [29:0] IDX_LOOP = 30'h6;   // carrier loop filter control one
  localparam logic [29:0] IDX_STAT = 30'h10;  // status, read only

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [7:0] DISC_RST  = 8'h00;
  localparam logic [7:0] FED_RST   = 8'h00;
  localparam logic [7:0] LOOP_RST  = 8'h00;
  localparam logic [2:0] MAX_K     = 3'h4;    // longest delay is 2^4 samples
  localparam logic [2:0] MAX_SHIFT = 3'h4;    // left shift 0..4
  localparam int         LF_GAP_CYC = 6;      // loop filter input spacing in clocks
  localparam int         DLY_DEPTH  = 16;     // discriminator delay line length
  localparam int         OFS_W      = 5;      // offset width, summed into the top bits

  // ****************************************
  // field layouts
  // ****************************************
  // frequency error detector control: offset in 7:3, shift in 2:0
  typedef struct packed {
    logic [4:0] freqOffset;
    logic [2:0] shift;
  } fed_cfg_type;

  // loop filter control one: reserved 7, serial routing 6, nco routing 5, count-1 in 4:0
  typedef struct packed {
    logic       rsvd;
    logic       serSum;
    logic       ncoLead;
    logic [4:0] accumLess1;
  } loop_cfg_type;

  // loop filter input pacing
  typedef enum logic [2:0] {
    LF_IDLE = 3'b001,
    LF_GAP  = 3'b010,
    LF_PEND = 3'b100
  } lf_state_type;

endpackage

// File: carrier_freq_error_loop_control.sv
// Purpose: frequency error detector and carrier loop filter input and routing stage
// Assumes: one clock, sample strobes synchronous to it, AHB-Lite single word transfers
// Notes:   zero wait state slave; control changes take effect at batch boundaries
//
// How it works
// - offset added to frequency with wrap-around
// - offset is 5-bit signed fraction
// - offset summed only into five top bits
// - frequency error shifted left 0 to 4
// - serial output gets lag or lead-plus-lag
// - NCO gets top 32 bits, sum or lead
// - count+1 error measurements accumulated per batch
// - loop filter input at most every six clocks
// - frequency is phase minus phase 2^K back

`timescale 1ns/1ps

module carrier_freq_error_loop_control
  import carrier_loop_pkg::*;
#(
  parameter int PW = 8,   // phase and frequency word width
  parameter int EW = 8,   // phase error width
  parameter int LW = 40,  // lead and lag path width
  parameter int NW = 32   // nco control word width
)(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  input  wire logic          sampleValid,
  input  wire logic [PW-1:0] phaseIn,
  input  wire logic [EW-1:0] phaseErr,
  input  wire logic [LW-1:0] leadIn,
  input  wire logic [LW-1:0] lagIn,
  output logic               filtRun,
  output logic [EW+5:0]      filtPhErr,
  output logic [PW+5:0]      filtFrErr,
  output logic [LW-1:0]      serOut,
  output logic [NW-1:0]      ncoOut
);

  localparam int AW = EW + 6;   // phase sums: 32 terms plus one pending batch
  localparam int FW = PW + 6;   // frequency sums
  localparam logic [2:0] GAP_LAST = 3'(LF_GAP_CYC - 1);

  // word-aligned register hit, used for both write and read decode
  function automatic logic regHit(input logic [31:0] a, input logic [29:0] idx);
    return (a[31:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // ****************************************
  // register bus slave
  // ****************************************
  logic [7:0]   discReg_ff, fedReg_ff, loopReg_ff;
  logic [7:0]   nxt_discReg, nxt_fedReg, nxt_loopReg;
  logic         wrPend_ff;
  logic [31:0]  wrAddr_ff;
  logic [31:0]  readVal;
  logic [31:0]  statusWord;
  wire          apValid = hsel && htrans[1] && hready;

  // data phase write; next values also feed readback so a read right after a write is fresh
  assign nxt_discReg = (wrPend_ff && regHit(wrAddr_ff, IDX_DISC)) ? hwdata[7:0] : discReg_ff;
  assign nxt_fedReg  = (wrPend_ff && regHit(wrAddr_ff, IDX_FED))  ? hwdata[7:0] : fedReg_ff;
  assign nxt_loopReg = (wrPend_ff && regHit(wrAddr_ff, IDX_LOOP)) ? hwdata[7:0] : loopReg_ff;
  assign readVal = regHit(haddr, IDX_DISC) ? {24'h000000, nxt_discReg} :
                   regHit(haddr, IDX_FED)  ? {24'h000000, nxt_fedReg}  :
                   regHit(haddr, IDX_LOOP) ? {24'h000000, nxt_loopReg} :
                   regHit(haddr, IDX_STAT) ? statusWord : 32'h00000000;

  // address phase capture, readback and always-OKAY answer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend_ff  <= 1'b0;
      wrAddr_ff  <= 32'h00000000;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      discReg_ff <= DISC_RST;
      fedReg_ff  <= FED_RST;
      loopReg_ff <= LOOP_RST;
    end else begin
      wrPend_ff  <= apValid && hwrite;
      wrAddr_ff  <= apValid ? haddr : wrAddr_ff;
      hrdata     <= (apValid && !hwrite) ? readVal : 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      discReg_ff <= nxt_discReg;
      fedReg_ff  <= nxt_fedReg;
      loopReg_ff <= nxt_loopReg;
    end
  end

  // ****************************************
  // active settings, reloaded between batches
  // ****************************************
  fed_cfg_type  fedAct_ff;
  loop_cfg_type loopAct_ff;
  logic [2:0]   kAct_ff;
  logic [4:0]   batchCnt_ff;
  logic         batchDone;
  wire          loadCfg = batchDone || (batchCnt_ff == 5'h00 && !sampleValid);

  // settings never change inside a running accumulation
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fedAct_ff  <= fed_cfg_type'(FED_RST);
      loopAct_ff <= loop_cfg_type'(LOOP_RST);
      kAct_ff    <= DISC_RST[2:0];
    end else if (loadCfg) begin
      fedAct_ff  <= fed_cfg_type'(fedReg_ff);
      loopAct_ff <= loop_cfg_type'(loopReg_ff);
      kAct_ff    <= discReg_ff[2:0];
    end
  end

  // ****************************************
  // discriminator, offset and shift
  // ****************************************
  logic [PW-1:0] dly_ff [0:DLY_DEPTH-1];
  wire [2:0]     kEff   = (kAct_ff > MAX_K) ? MAX_K : kAct_ff;
  wire [3:0]     tapIdx = 4'((5'h01 << kEff) - 5'h01);
  wire [PW-1:0]  freqRaw = phaseIn - dly_ff[tapIdx];
  wire [OFS_W-1:0] offTop = freqRaw[PW-1 -: OFS_W] + fedAct_ff.freqOffset;
  wire [PW-1:0]  freqOff = {offTop, freqRaw[PW-OFS_W-1:0]};
  wire [2:0]     shEff  = (fedAct_ff.shift > MAX_SHIFT) ? MAX_SHIFT : fedAct_ff.shift;
  wire [PW-1:0]  freqErr = PW'(freqOff << shEff);

  // phase history, one step per sample
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dly_ff[0] <= '0;
    end else if (sampleValid) begin
      dly_ff[0] <= phaseIn;
    end
  end

  generate
    for (genvar i = 1; i < DLY_DEPTH; i++) begin : g_dly
      // delay line stage
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          dly_ff[i] <= '0;
        end else if (sampleValid) begin
          dly_ff[i] <= dly_ff[i-1];
        end
      end
    end
  endgenerate

  // ****************************************
  // error accumulation
  // ****************************************
  logic [AW-1:0] accPh_ff, heldPh_ff, combPh;
  logic [FW-1:0] accFr_ff, heldFr_ff, combFr;
  wire  [AW-1:0] batchPh = accPh_ff + {{(AW-EW){phaseErr[EW-1]}}, phaseErr};
  wire  [FW-1:0] batchFr = accFr_ff + {{(FW-PW){freqErr[PW-1]}}, freqErr};

  assign batchDone = sampleValid && (batchCnt_ff == loopAct_ff.accumLess1);
  assign combPh = heldPh_ff + (batchDone ? batchPh : '0);
  assign combFr = heldFr_ff + (batchDone ? batchFr : '0);

  // count measurements; a full batch restarts the sums
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      batchCnt_ff <= 5'h00;
      accPh_ff    <= '0;
      accFr_ff    <= '0;
    end else if (sampleValid) begin
      batchCnt_ff <= batchDone ? 5'h00 : batchCnt_ff + 5'h01;
      accPh_ff    <= batchDone ? '0 : batchPh;
      accFr_ff    <= batchDone ? '0 : batchFr;
    end
  end

  // ****************************************
  // loop filter pacing
  // ****************************************
  lf_state_type lfState_ff, nxt_lfState;
  logic [2:0]   gapCnt_ff;
  logic         issue;
  wire          gapEnd = (lfState_ff != LF_IDLE) && (gapCnt_ff == GAP_LAST);

  // a batch finishing inside the gap waits, summed with any later batch
  always_comb begin
    nxt_lfState = lfState_ff;
    issue = 1'b0;
    case (lfState_ff)
      LF_IDLE: begin
        if (batchDone) begin
          issue = 1'b1;
          nxt_lfState = LF_GAP;
        end
      end
      LF_GAP: begin
        if (gapEnd) begin
          issue = batchDone;
          nxt_lfState = batchDone ? LF_GAP : LF_IDLE;
        end else if (batchDone) begin
          nxt_lfState = LF_PEND;
        end
      end
      LF_PEND: begin
        if (gapEnd) begin
          issue = 1'b1;
          nxt_lfState = LF_GAP;
        end
      end
      default: begin
        nxt_lfState = LF_IDLE;
      end
    endcase
  end

  // gap counter, held sums and loop filter input
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lfState_ff <= LF_IDLE;
      gapCnt_ff  <= 3'h0;
      heldPh_ff  <= '0;
      heldFr_ff  <= '0;
      filtRun    <= 1'b0;
      filtPhErr  <= '0;
      filtFrErr  <= '0;
    end else begin
      lfState_ff <= nxt_lfState;
      gapCnt_ff  <= issue ? 3'h0 : (gapEnd ? gapCnt_ff : gapCnt_ff + 3'h1);
      heldPh_ff  <= issue ? '0 : combPh;
      heldFr_ff  <= issue ? '0 : combFr;
      filtRun    <= issue;
      filtPhErr  <= issue ? combPh : filtPhErr;
      filtFrErr  <= issue ? combFr : filtFrErr;
    end
  end

  assign statusWord = {24'h000000, lfState_ff == LF_PEND, 2'b00, batchCnt_ff};

  // ****************************************
  // output routing
  // ****************************************
  wire [LW-1:0] leadLag = leadIn + lagIn;
  wire [LW-1:0] ncoSrc  = loopAct_ff.ncoLead ? leadIn : leadLag;

  // serial controller and nco words
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serOut <= '0;
      ncoOut <= '0;
    end else begin
      serOut <= loopAct_ff.serSum ? leadLag : lagIn;
      ncoOut <= ncoSrc[LW-1 -: NW];
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_quiet;
    !filtRun [*5];
  endsequence

  property p_spacing;
    @(posedge clock) disable iff (sys_rst) filtRun |=> s_quiet;
  endproperty
  a_spacing: assert property (p_spacing) else $error("loop filter run too soon");

  property p_pend;
    @(posedge clock) disable iff (sys_rst) (lfState_ff == LF_PEND && gapEnd) |=> filtRun;
  endproperty
  a_pend: assert property (p_pend) else $error("pending batch lost");

  property p_first;
    @(posedge clock) disable iff (sys_rst)
      (lfState_ff == LF_IDLE && batchDone) |=> (filtRun && filtPhErr == $past(combPh));
  endproperty
  a_first: assert property (p_first) else $error("batch not passed on");

  property p_low;
    @(posedge clock) disable iff (sys_rst)
      (sampleValid && shEff == 3'h0) |-> freqErr[PW-OFS_W-1:0] == freqRaw[PW-OFS_W-1:0];
  endproperty
  a_low: assert property (p_low) else $error("offset touched low bits");

  property p_shift;
    @(posedge clock) disable iff (sys_rst)
      (shEff == 3'h2) |-> (freqErr[1:0] == 2'b00 && freqErr[PW-1:2] == freqOff[PW-3:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift by two wrong");

  property p_disc;
    @(posedge clock) disable iff (sys_rst)
      (sampleValid ##1 (sampleValid && kEff == 3'h0)) |-> freqRaw == phaseIn - $past(phaseIn);
  endproperty
  a_disc: assert property (p_disc) else $error("one sample difference wrong");

  property p_cfg;
    @(posedge clock) disable iff (sys_rst) !loadCfg |=> $stable(loopAct_ff);
  endproperty
  a_cfg: assert property (p_cfg) else $error("settings changed mid batch");

  property p_ser;
    @(posedge clock) disable iff (sys_rst)
      (!sys_rst && !loopAct_ff.serSum) |=> serOut == $past(lagIn);
  endproperty
  a_ser: assert property (p_ser) else $error("serial route not lag");

  property p_nco;
    @(posedge clock) disable iff (sys_rst)
      (!sys_rst && loopAct_ff.ncoLead) |=> ncoOut == $past(leadIn[LW-1 -: NW]);
  endproperty
  a_nco: assert property (p_nco) else $error("nco route not lead");

endmodule

// File: carrier_freq_error_loop_control_tb.sv
// Purpose: self-checking bench for the carrier frequency error and loop input stage
// Assumes: zero wait state slave, settings copied to the active set at batch boundaries
// Notes:   reference model lives in the monitor process; data from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module carrier_freq_error_loop_control_tb
  import carrier_loop_pkg::*;
;
  logic         clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
  logic         sampleValid, filtRun;
  logic [31:0]  haddr, hwdata, hrdata, ncoOut, expNco;
  logic [1:0]   htrans;
  logic [2:0]   hsize, shK, actK;
  logic [7:0]   phaseIn, phaseErr, fr;
  logic [39:0]  leadIn, lagIn, serOut, expSer, sum40;
  logic [13:0]  filtPhErr, filtFrErr, rdyPh, rdyFr, outPh, outFr;
  logic [7:0]   hist [16];
  logic [4:0]   cl [4] = '{5'h1, 5'h3, 5'h1f, 5'h2};
  fed_cfg_type  shFed, actFed;
  loop_cfg_type shLoop, actLoop;
  int           failures, cmp_count, cnt, lastRun, age;
  bit           exact, expRun;

  // ****************************************
  // clock, bus loop-back, design
  // ****************************************
  always #10 clock = ~clock;
  assign hready = hreadyout;
  carrier_freq_error_loop_control dut_u (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sampleValid(sampleValid), .phaseIn(phaseIn), .phaseErr(phaseErr), .leadIn(leadIn),
    .lagIn(lagIn), .filtRun(filtRun), .filtPhErr(filtPhErr), .filtFrErr(filtFrErr),
    .serOut(serOut), .ncoOut(ncoOut));

  // ****************************************
  // stimulus and bus tasks
  // ****************************************
  // lead and lag terms change every cycle; lead stands for a gain already scaled per batch
  always @(posedge clock) begin
    leadIn <= {8'($urandom), $urandom};
    lagIn  <= {8'($urandom), $urandom};
  end

  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w; hsize <= 3'h2;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
    `CHK(hresp, 1'b0)
    if (w && a == {IDX_FED, 2'b00}) shFed <= d[7:0];
    if (w && a == {IDX_LOOP, 2'b00}) shLoop <= d[7:0];
    if (w && a == {IDX_DISC, 2'b00}) shK <= d[2:0];
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [31:0] a, e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask

  // n measurements, gap idle cycles after each
  task automatic send(input int n, gap);
    for (int i = 0; i < n; i++) begin
      phaseIn <= 8'($urandom); phaseErr <= 8'($urandom); sampleValid <= 1'b1;
      @(posedge clock);
      if (gap > 0) begin sampleValid <= 1'b0; repeat (gap) @(posedge clock); end
    end
    sampleValid <= 1'b0;
  endtask

  task automatic rst_pulse;
    sys_rst <= 1'b1; shFed <= '0; shLoop <= '0; shK <= 3'h0;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask

  task automatic fin(input string n);
    $display("test %s done", n);
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ****************************************
  // reference model
  // ****************************************
  function automatic logic [7:0] frq(input logic [7:0] p, o, input fed_cfg_type c);
    logic [7:0] x;
    x = p - o + {c.freqOffset, 3'h0};
    return x << ((c.shift > MAX_SHIFT) ? MAX_SHIFT : c.shift);
  endfunction

  task automatic cpy;
    if ({actFed, actLoop, actK} != {shFed, shLoop, shK}) age = 0;
    actFed = shFed; actLoop = shLoop; actK = shK;
  endtask

  // checks outputs, then advances the model by one edge
  always @(posedge clock) begin
    if (sys_rst) begin
      foreach (hist[i]) hist[i] = 8'h0;
      cnt = 0; actFed = '0; actLoop = '0; actK = 3'h0; lastRun = 100; age = 0;
      rdyPh = '0; rdyFr = '0; outPh = '0; outFr = '0; expRun = 0;
    end else begin
      lastRun++;
      if (exact) `CHK(filtRun, expRun)
      if (filtRun === 1'b1) begin
        `CHK(lastRun >= 6, 1'b1)
        lastRun = 0;
        if (exact) begin
          `CHK(filtPhErr, rdyPh)
          `CHK(filtFrErr, rdyFr)
          rdyPh = '0; rdyFr = '0;
        end else begin outPh += filtPhErr; outFr += filtFrErr; end
      end
      if (age >= 2) begin `CHK(serOut, expSer) `CHK(ncoOut, expNco) end
      sum40 = leadIn + lagIn;
      expSer = actLoop.serSum ? sum40 : lagIn;
      expNco = actLoop.ncoLead ? leadIn[39:8] : sum40[39:8];
      age++; expRun = 0;
      if (sampleValid === 1'b1) begin
        fr = frq(phaseIn, hist[(1 << ((actK > MAX_K) ? MAX_K : actK)) - 1], actFed);
        for (int i = 15; i > 0; i--) hist[i] = hist[i-1];
        hist[0] = phaseIn;
        rdyPh += {{6{phaseErr[7]}}, phaseErr};
        rdyFr += {{6{fr[7]}}, fr};
        cnt++;
        if (cnt == actLoop.accumLess1 + 1) begin cnt = 0; expRun = 1; cpy(); end
      end else if (cnt == 0) cpy();
    end
  end

  initial begin
    repeat (30000) @(posedge clock);
    failures++;
    test_done();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    logic [31:0] v;
    clock = 0; sys_rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; sampleValid = 0; phaseIn = 0; phaseErr = 0; leadIn = 0; lagIn = 0;
    failures = 0; cmp_count = 0; exact = 1;
    void'($urandom(50372));
    rst_pulse();
    rd(32'h14, 32'h0);
    rd(32'h18, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(32'h18, {v[31:8], 1'b0, v[6:0]});
      rd(32'h18, {24'h0, 1'b0, v[6:0]});
    end
    wr(32'h24, v); rd(32'h24, 32'h0); rd(32'h15, 32'h0);
    wr(32'h40, v); rd(32'h40, 32'h0);
    wr(32'h18, 32'h0);
    fin("registers");
    for (int s = 0; s < 5; s++) begin
      v = $urandom;
      wr(32'h10, 32'(s)); wr(32'h14, {24'h0, v[7:3], 3'(s)});
      repeat (3) @(posedge clock);
      send(20, 8);
    end
    fin("frequency");
    for (int i = 0; i < 4; i++) begin
      wr(32'h18, {24'h0, 1'b0, 2'(i), cl[i]});
      repeat (3) @(posedge clock);
      send(2 * (cl[i] + 1), 8);
    end
    fin("accumulate");
    exact = 0;
    for (int i = 0; i < 2; i++) begin
      wr(32'h10, 32'(i));
      wr(32'h18, 32'(i));
      repeat (3) @(posedge clock);
      send(40, 0);
      repeat (20) @(posedge clock);
      `CHK(outPh, rdyPh)
      `CHK(outFr, rdyFr)
      rdyPh = '0; rdyFr = '0; outPh = '0; outFr = '0;
    end
    exact = 1;
    fin("fast");
    wr(32'h14, 32'h0);
    wr(32'h18, 32'h43);
    repeat (3) @(posedge clock);
    send(2, 8);
    wr(32'h14, 32'h2a); wr(32'h18, 32'h20);
    send(5, 8);
    fin("midbatch");
    wr(32'h14, 32'h2b);
    rst_pulse();
    rd(32'h14, 32'h0);
    rd(32'h18, 32'h0);
    fin("reset");
    test_done();
  end
endmodule
